// ---- poe_defs.svh ----
/*
  Offsets, field positions, reset values and decode codes of the pin
  output-enable decode block.
  Assumes byte addresses on a 32-bit classic Wishbone bus, one word per register.
*/
// Behaviour
// RQ1 - Timer pin A/B enabled when control top bit 0 and low bits nonzero.
// RQ2 - Timer pin D enabled when buffer-op-B 0 and D control field enables.
// RQ3 - Timer pin C enabled when buffer-op-A 0 and C control field enables.
// RQ4 - Timers 7 and 8 pins A/B use the same control field test.
// RQ5 - CAN pin enabled by any transmit mailbox 1-15 pending, controller on, not stopped.
// RQ6 - Smart-card mode: clock pin on if transmit or receive and (special mode or field 01).
// RQ7 - Normal mode: clock pin on if tx or rx, async field 01 or sync bit1 zero.
// RQ8 - Clock output pin on when direction 1, clock stop 0, select 0.
// RQ9 - Clocked master: data-out on with transmit, and bidir 0 or receive off.
// RQ10 - Clocked slave: data-out on only when bidir 1, receive off, transmit on.
// RQ11 - Alternate serial mode: data-out on whenever transmit is enabled.
// RQ12 - Data-in pin driven only as clocked slave, bidir 0, transmit on.
// RQ13 - Serial clock pin driven when master and internal clock selected.
// RQ14 - Chip-select pin driven when select field bit1 set, clocked mode, master.
// RQ15 - Enables are combinational from register bits; low means port logic owns pin.
`ifndef POE_DEFS_SVH
`define POE_DEFS_SVH

// ==========================================================
// Register offsets
`define POE_OFS_TMR0     8'h00
`define POE_OFS_TMR6     8'h04
`define POE_OFS_TMR78    8'h08
`define POE_OFS_CAN_MBOX 8'h0C
`define POE_OFS_CAN_CTRL 8'h10
`define POE_OFS_SCI4     8'h14
`define POE_OFS_CLKOUT   8'h18
`define POE_OFS_SSU0     8'h1C
`define POE_OFS_SSU1     8'h20
`define POE_OFS_SSU2     8'h24
`define POE_OFS_STATUS   8'h28

// ==========================================================
// Writable masks and reset values
`define POE_MASK_TMR0     32'h0000_000F
`define POE_MASK_TMR6     32'h0003_FFFF
`define POE_MASK_TMR78    32'h0000_FFFF
`define POE_MASK_CAN_MBOX 32'hFFFF_FFFF
`define POE_MASK_CAN_CTRL 32'h0000_0003
`define POE_MASK_SCI4     32'h0000_007F
`define POE_MASK_CLKOUT   32'h0000_0007
`define POE_MASK_SSU      32'h0000_00FF
`define POE_RST_REG       32'h0000_0000
`define POE_RD_UNMAPPED   32'h0000_0000

// ==========================================================
// Field positions
`define POE_CTRL_W     4
`define POE_CTRL_TOP   3
`define POE_FLD_A      0
`define POE_FLD_B      4
`define POE_FLD_C      8
`define POE_FLD_D      12
`define POE_BIT_BUFA   16
`define POE_BIT_BUFB   17
`define POE_FLD_T7A    0
`define POE_FLD_T7B    4
`define POE_FLD_T8A    8
`define POE_FLD_T8B    12
`define POE_CAN_DIR    15:0
`define POE_CAN_TXP    31:16
`define POE_CAN_MBOXES 16'hFFFE
`define POE_BIT_CAN_EN   0
`define POE_BIT_CAN_STOP 1
`define POE_BIT_SMART  0
`define POE_BIT_SPCLK  1
`define POE_BIT_SYNC   2
`define POE_FLD_CKE    3
`define POE_BIT_SCI_TX 5
`define POE_BIT_SCI_RX 6
`define POE_CKE_OUT    2'h1
`define POE_BIT_A7DIR  0
`define POE_BIT_PSTOP  1
`define POE_BIT_OSEL   2
`define POE_BIT_SSUMOD 0
`define POE_BIT_MASTER 1
`define POE_BIT_BIDIR  2
`define POE_BIT_SCKSEL 3
`define POE_BIT_CSHI   5
`define POE_BIT_SSU_TX 6
`define POE_BIT_SSU_RX 7
`define POE_SSU_COUNT  3

`endif

// ---- poe_pkg.sv ----
/*
  Types of the pin output-enable decode block.
  Assumes poe_defs.svh supplies all numeric constants.
*/
package poe_pkg;

  typedef logic [31:0] poe_word_t;
  typedef logic [3:0]  poe_ctrl_t;

  typedef enum {
    poe_reg_tmr0,
    poe_reg_tmr6,
    poe_reg_tmr78,
    poe_reg_can_mbox,
    poe_reg_can_ctrl,
    poe_reg_sci4,
    poe_reg_clkout,
    poe_reg_ssu0,
    poe_reg_ssu1,
    poe_reg_ssu2,
    poe_reg_status,
    poe_reg_none
  } poe_reg_e;

endpackage

// ---- poe_ssu_decode.sv ----
/*
  Output-enable decode of one synchronous serial channel.
  Assumes its inputs are stable register bits; purely combinational.
*/
`timescale 1ns/100ps

module poe_ssu_decode
(
  input  wire logic mode_sel,
  input  wire logic master,
  input  wire logic bidir,
  input  wire logic clk_sel,
  input  wire logic cs_hi,
  input  wire logic tx_en,
  input  wire logic rx_en,
  output logic      data_out_oe,
  output logic      data_in_oe,
  output logic      clock_oe,
  output logic      chip_select_oe
);

  logic clocked;

  assign clocked = ~mode_sel;

  // ==========================================================
  // Pin enables
  always_comb
  begin
    if (mode_sel)
    begin
      data_out_oe = tx_en; // RQ11
    end
    else if (master)
    begin
      data_out_oe = tx_en & (~bidir | ~rx_en); // RQ9
    end
    else
    begin
      data_out_oe = bidir & ~rx_en & tx_en; // RQ10
    end
  end

  // Slave drives the input pin only in two-wire output mode
  assign data_in_oe     = clocked & ~master & ~bidir & tx_en; // RQ12
  assign clock_oe       = master & clk_sel; // RQ13
  // Low select bit does not matter
  assign chip_select_oe = cs_hi & clocked & master; // RQ14

endmodule

// ---- poe_decode.sv ----
/*
  Pin output-enable decode: Wishbone register slave holding copies of the
  peripheral setting bits, and the decode of every pad output enable.
  Assumes a classic Wishbone master on mclk; the pad logic falls back to
  port direction and data whenever an enable here is low.
*/
// Added by the designer: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/100ps
`include "poe_defs.svh"

module poe_decode
  import poe_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        arst_n,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             timer0_pin_a_oe,
  output logic             timer6_pin_a_oe,
  output logic             timer6_pin_b_oe,
  output logic             timer6_pin_c_oe,
  output logic             timer6_pin_d_oe,
  output logic             timer7_pin_a_oe,
  output logic             timer7_pin_b_oe,
  output logic             timer8_pin_a_oe,
  output logic             timer8_pin_b_oe,
  output logic             can_transmit_pin_oe,
  output logic             serial4_clock_pin_oe,
  output logic             clock_out_oe,
  output logic      [2:0]  sync_serial_data_out_oe,
  output logic      [2:0]  sync_serial_data_in_oe,
  output logic      [2:0]  sync_serial_clock_pin_oe,
  output logic      [2:0]  sync_serial_chip_select_oe
);

  // ==========================================================
  // Functions

  function automatic logic ctrl_oe(input poe_ctrl_t fld);
    ctrl_oe = ~fld[`POE_CTRL_TOP] & (|fld[1:0]);
  endfunction

  function automatic poe_reg_e reg_sel(input logic [7:0] adr);
    if (adr == `POE_OFS_TMR0)
      reg_sel = poe_reg_tmr0;
    else if (adr == `POE_OFS_TMR6)
      reg_sel = poe_reg_tmr6;
    else if (adr == `POE_OFS_TMR78)
      reg_sel = poe_reg_tmr78;
    else if (adr == `POE_OFS_CAN_MBOX)
      reg_sel = poe_reg_can_mbox;
    else if (adr == `POE_OFS_CAN_CTRL)
      reg_sel = poe_reg_can_ctrl;
    else if (adr == `POE_OFS_SCI4)
      reg_sel = poe_reg_sci4;
    else if (adr == `POE_OFS_CLKOUT)
      reg_sel = poe_reg_clkout;
    else if (adr == `POE_OFS_SSU0)
      reg_sel = poe_reg_ssu0;
    else if (adr == `POE_OFS_SSU1)
      reg_sel = poe_reg_ssu1;
    else if (adr == `POE_OFS_SSU2)
      reg_sel = poe_reg_ssu2;
    else if (adr == `POE_OFS_STATUS)
      reg_sel = poe_reg_status;
    else
      reg_sel = poe_reg_none;
  endfunction

  // Byte-lane merge; unused bits are forced low so they read as zero
  function automatic poe_word_t merge(input poe_word_t cur,
                                      input poe_word_t wr,
                                      input poe_word_t mask,
                                      input logic [3:0] sel);
    poe_word_t res;
    res = cur;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
        res[8*i +: 8] = wr[8*i +: 8];
    end
    merge = res & mask;
  endfunction

  // ==========================================================
  // Register state

  poe_word_t tmr0;
  poe_word_t tmr6;
  poe_word_t tmr78;
  poe_word_t can_mbox;
  poe_word_t can_ctrl;
  poe_word_t sci4;
  poe_word_t clkout;
  poe_word_t ssu      [`POE_SSU_COUNT];
  poe_word_t next_tmr0;
  poe_word_t next_tmr6;
  poe_word_t next_tmr78;
  poe_word_t next_can_mbox;
  poe_word_t next_can_ctrl;
  poe_word_t next_sci4;
  poe_word_t next_clkout;
  poe_word_t next_ssu [`POE_SSU_COUNT];
  poe_word_t next_dat;
  logic      next_ack;
  poe_word_t oe_status;
  poe_reg_e  acc;
  logic      req;

  assign req = wb_cyc_i & wb_stb_i;
  assign acc = reg_sel(wb_adr_i);

  // Read data is latched with the ack; a write lands on the edge that ends the ack cycle
  always_comb
  begin
    poe_word_t rd;
    rd            = `POE_RD_UNMAPPED;
    next_tmr0     = tmr0;
    next_tmr6     = tmr6;
    next_tmr78    = tmr78;
    next_can_mbox = can_mbox;
    next_can_ctrl = can_ctrl;
    next_sci4     = sci4;
    next_clkout   = clkout;
    next_ssu      = ssu;
    next_ack      = req & ~wb_ack_o;
    next_dat      = wb_dat_o;
    if (acc == poe_reg_tmr0)
      rd = tmr0;
    else if (acc == poe_reg_tmr6)
      rd = tmr6;
    else if (acc == poe_reg_tmr78)
      rd = tmr78;
    else if (acc == poe_reg_can_mbox)
      rd = can_mbox;
    else if (acc == poe_reg_can_ctrl)
      rd = can_ctrl;
    else if (acc == poe_reg_sci4)
      rd = sci4;
    else if (acc == poe_reg_clkout)
      rd = clkout;
    else if (acc == poe_reg_ssu0)
      rd = ssu[0];
    else if (acc == poe_reg_ssu1)
      rd = ssu[1];
    else if (acc == poe_reg_ssu2)
      rd = ssu[2];
    else if (acc == poe_reg_status)
      rd = oe_status;
    if (next_ack)
      next_dat = rd;
    if (req & wb_we_i & wb_ack_o)
    begin
      if (acc == poe_reg_tmr0)
        next_tmr0 = merge(tmr0, wb_dat_i, `POE_MASK_TMR0, wb_sel_i);
      else if (acc == poe_reg_tmr6)
        next_tmr6 = merge(tmr6, wb_dat_i, `POE_MASK_TMR6, wb_sel_i);
      else if (acc == poe_reg_tmr78)
        next_tmr78 = merge(tmr78, wb_dat_i, `POE_MASK_TMR78, wb_sel_i);
      else if (acc == poe_reg_can_mbox)
        next_can_mbox = merge(can_mbox, wb_dat_i, `POE_MASK_CAN_MBOX, wb_sel_i);
      else if (acc == poe_reg_can_ctrl)
        next_can_ctrl = merge(can_ctrl, wb_dat_i, `POE_MASK_CAN_CTRL, wb_sel_i);
      else if (acc == poe_reg_sci4)
        next_sci4 = merge(sci4, wb_dat_i, `POE_MASK_SCI4, wb_sel_i);
      else if (acc == poe_reg_clkout)
        next_clkout = merge(clkout, wb_dat_i, `POE_MASK_CLKOUT, wb_sel_i);
      else if (acc == poe_reg_ssu0)
        next_ssu[0] = merge(ssu[0], wb_dat_i, `POE_MASK_SSU, wb_sel_i);
      else if (acc == poe_reg_ssu1)
        next_ssu[1] = merge(ssu[1], wb_dat_i, `POE_MASK_SSU, wb_sel_i);
      else if (acc == poe_reg_ssu2)
        next_ssu[2] = merge(ssu[2], wb_dat_i, `POE_MASK_SSU, wb_sel_i);
    end
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tmr0     <= `POE_RST_REG;
      tmr6     <= `POE_RST_REG;
      tmr78    <= `POE_RST_REG;
      can_mbox <= `POE_RST_REG;
      can_ctrl <= `POE_RST_REG;
      sci4     <= `POE_RST_REG;
      clkout   <= `POE_RST_REG;
      for (int i = 0; i < `POE_SSU_COUNT; i++)
        ssu[i] <= `POE_RST_REG;
      wb_ack_o <= 1'b0;
      wb_dat_o <= `POE_RST_REG;
    end
    else
    begin
      tmr0     <= next_tmr0;
      tmr6     <= next_tmr6;
      tmr78    <= next_tmr78;
      can_mbox <= next_can_mbox;
      can_ctrl <= next_can_ctrl;
      sci4     <= next_sci4;
      clkout   <= next_clkout;
      ssu      <= next_ssu;
      wb_ack_o <= next_ack;
      wb_dat_o <= next_dat;
    end
  end

  // ==========================================================
  // Timer pin enables
  // No pipeline stage: an enable follows its register in the same cycle

  assign timer0_pin_a_oe = ctrl_oe(tmr0[`POE_FLD_A +: `POE_CTRL_W]); // RQ1 RQ15
  assign timer6_pin_a_oe = ctrl_oe(tmr6[`POE_FLD_A +: `POE_CTRL_W]); // RQ1
  assign timer6_pin_b_oe = ctrl_oe(tmr6[`POE_FLD_B +: `POE_CTRL_W]); // RQ1
  // Buffer operation borrows pins C and D as buffer registers
  assign timer6_pin_c_oe = ~tmr6[`POE_BIT_BUFA]
                         & ctrl_oe(tmr6[`POE_FLD_C +: `POE_CTRL_W]); // RQ3
  assign timer6_pin_d_oe = ~tmr6[`POE_BIT_BUFB]
                         & ctrl_oe(tmr6[`POE_FLD_D +: `POE_CTRL_W]); // RQ2
  assign timer7_pin_a_oe = ctrl_oe(tmr78[`POE_FLD_T7A +: `POE_CTRL_W]); // RQ4
  assign timer7_pin_b_oe = ctrl_oe(tmr78[`POE_FLD_T7B +: `POE_CTRL_W]); // RQ4
  assign timer8_pin_a_oe = ctrl_oe(tmr78[`POE_FLD_T8A +: `POE_CTRL_W]); // RQ4
  assign timer8_pin_b_oe = ctrl_oe(tmr78[`POE_FLD_T8B +: `POE_CTRL_W]); // RQ4

  // ==========================================================
  // CAN, serial clock and system clock output

  logic [15:0] can_tx_ready;
  logic [1:0]  sci_cke;
  logic        sci_run;
  logic        sci_smart_oe;
  logic        sci_norm_oe;

  // Mailbox 0 is never counted
  assign can_tx_ready = ~can_mbox[`POE_CAN_DIR] & can_mbox[`POE_CAN_TXP]
                      & `POE_CAN_MBOXES;
  assign can_transmit_pin_oe = (|can_tx_ready) & can_ctrl[`POE_BIT_CAN_EN]
                             & ~can_ctrl[`POE_BIT_CAN_STOP]; // RQ5

  assign sci_cke      = sci4[`POE_FLD_CKE +: 2];
  assign sci_run      = sci4[`POE_BIT_SCI_TX] | sci4[`POE_BIT_SCI_RX];
  assign sci_smart_oe = sci_run
                      & (sci4[`POE_BIT_SPCLK] | (sci_cke == `POE_CKE_OUT)); // RQ6
  assign sci_norm_oe  = sci_run & (sci4[`POE_BIT_SYNC] ? ~sci_cke[1]
                                                       : (sci_cke == `POE_CKE_OUT)); // RQ7
  assign serial4_clock_pin_oe = sci4[`POE_BIT_SMART] ? sci_smart_oe : sci_norm_oe;

  assign clock_out_oe = clkout[`POE_BIT_A7DIR] & ~clkout[`POE_BIT_PSTOP]
                      & ~clkout[`POE_BIT_OSEL]; // RQ8

  // ==========================================================
  // Synchronous serial channels

  for (genvar g = 0; g < `POE_SSU_COUNT; g++)
  begin : g_ssu
    poe_ssu_decode u_ssu
    (
      .mode_sel       (ssu[g][`POE_BIT_SSUMOD]),
      .master         (ssu[g][`POE_BIT_MASTER]),
      .bidir          (ssu[g][`POE_BIT_BIDIR]),
      .clk_sel        (ssu[g][`POE_BIT_SCKSEL]),
      .cs_hi          (ssu[g][`POE_BIT_CSHI]),
      .tx_en          (ssu[g][`POE_BIT_SSU_TX]),
      .rx_en          (ssu[g][`POE_BIT_SSU_RX]),
      .data_out_oe    (sync_serial_data_out_oe[g]),
      .data_in_oe     (sync_serial_data_in_oe[g]),
      .clock_oe       (sync_serial_clock_pin_oe[g]),
      .chip_select_oe (sync_serial_chip_select_oe[g])
    );
  end

  // ==========================================================
  // Status readback of every live enable

  assign oe_status = {8'h00,
                      sync_serial_chip_select_oe,
                      sync_serial_clock_pin_oe,
                      sync_serial_data_in_oe,
                      sync_serial_data_out_oe,
                      clock_out_oe,
                      serial4_clock_pin_oe,
                      can_transmit_pin_oe,
                      timer8_pin_b_oe,
                      timer8_pin_a_oe,
                      timer7_pin_b_oe,
                      timer7_pin_a_oe,
                      timer6_pin_d_oe,
                      timer6_pin_c_oe,
                      timer6_pin_b_oe,
                      timer6_pin_a_oe,
                      timer0_pin_a_oe};

endmodule

// ---- poe_decode_chk.sv ----
/*
  Port-level checks of the pin output-enable decode.
  Assumes a bind onto poe_decode, one clock, asynchronous active-low reset.
*/
`timescale 1ns/100ps
`include "poe_defs.svh"

module poe_decode_chk
  import poe_pkg::*;
(
  input wire logic        mclk,
  input wire logic        arst_n,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        timer0_pin_a_oe,
  input wire logic        timer6_pin_a_oe,
  input wire logic        timer6_pin_b_oe,
  input wire logic        timer6_pin_c_oe,
  input wire logic        timer6_pin_d_oe,
  input wire logic        timer7_pin_a_oe,
  input wire logic        timer7_pin_b_oe,
  input wire logic        timer8_pin_a_oe,
  input wire logic        timer8_pin_b_oe,
  input wire logic        can_transmit_pin_oe,
  input wire logic        serial4_clock_pin_oe,
  input wire logic        clock_out_oe,
  input wire logic [2:0]  sync_serial_data_out_oe,
  input wire logic [2:0]  sync_serial_data_in_oe,
  input wire logic [2:0]  sync_serial_clock_pin_oe,
  input wire logic [2:0]  sync_serial_chip_select_oe
);
  // ==========================================================
  // Helpers
  logic [23:0] oe_all;
  logic        st_rd;
  assign oe_all = {sync_serial_chip_select_oe, sync_serial_clock_pin_oe, sync_serial_data_in_oe,
                   sync_serial_data_out_oe, clock_out_oe, serial4_clock_pin_oe,
                   can_transmit_pin_oe, timer8_pin_b_oe, timer8_pin_a_oe, timer7_pin_b_oe,
                   timer7_pin_a_oe, timer6_pin_d_oe, timer6_pin_c_oe, timer6_pin_b_oe,
                   timer6_pin_a_oe, timer0_pin_a_oe};
  assign st_rd = wb_ack_o && !wb_we_i && wb_adr_i == `POE_OFS_STATUS;

  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);

  // ==========================================================
  // Properties
  ack_one_cycle_a:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
  ack_cause_a:
    assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i)) else $error("stray ack");
  ack_timely_a:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
  oe_hold_a:
    assert property (!(wb_ack_o && wb_we_i) |=> $stable(oe_all)) else $error("enable moved");
  status_timer_a:
    assert property (st_rd |-> wb_dat_o[8:0] == oe_all[8:0]) else $error("timer status");
  status_misc_a:
    assert property (st_rd |-> wb_dat_o[11:9] == oe_all[11:9]) else $error("misc status");
  status_ssu_a:
    assert property (st_rd |-> wb_dat_o[23:12] == oe_all[23:12]) else $error("ssu status");
  data_pins_excl_a:
    assert property ((sync_serial_data_in_oe & sync_serial_data_out_oe) == 3'h0)
      else $error("both data pins driven");
endmodule

bind poe_decode poe_decode_chk poe_decode_chk_inst (
  .mclk(mclk), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .timer0_pin_a_oe(timer0_pin_a_oe), .timer6_pin_a_oe(timer6_pin_a_oe),
  .timer6_pin_b_oe(timer6_pin_b_oe), .timer6_pin_c_oe(timer6_pin_c_oe),
  .timer6_pin_d_oe(timer6_pin_d_oe), .timer7_pin_a_oe(timer7_pin_a_oe),
  .timer7_pin_b_oe(timer7_pin_b_oe), .timer8_pin_a_oe(timer8_pin_a_oe),
  .timer8_pin_b_oe(timer8_pin_b_oe), .can_transmit_pin_oe(can_transmit_pin_oe),
  .serial4_clock_pin_oe(serial4_clock_pin_oe), .clock_out_oe(clock_out_oe),
  .sync_serial_data_out_oe(sync_serial_data_out_oe),
  .sync_serial_data_in_oe(sync_serial_data_in_oe),
  .sync_serial_clock_pin_oe(sync_serial_clock_pin_oe),
  .sync_serial_chip_select_oe(sync_serial_chip_select_oe));

// ---- poe_pad_model.sv ----
/*
  Pad ring beside the decode: each pin resolves peripheral, port and float.
  Assumes enables in status-word order, bit k for pin k.
*/
`timescale 1ns/100ps

module poe_pad_model
(
  input  wire logic [23:0] oe,
  input  wire logic [23:0] periph_dat,
  input  wire logic [23:0] port_dir,
  input  wire logic [23:0] port_dat,
  output logic      [23:0] pin
);
  // Floating pad shows a value matching no driver, so a stale level never passes
  assign pin = (oe & periph_dat)
             | (~oe & port_dir & port_dat)
             | (~oe & ~port_dir & ~periph_dat);
endmodule

// ---- poe_decode_tb.sv ----
/*
  Self-checking bench of the pin output-enable decode over Wishbone.
  Assumes poe_decode, poe_decode_chk and poe_pad_model are compiled first.
*/
`timescale 1ns/100ps
`include "poe_defs.svh"
`define CHK(g, e) \
  begin \
    checks_done++; \
    if ((g) !== (e)) \
      $display("CHECK FAILED at %0t got %h exp %h", $time, (g), (e)); \
    if ((g) !== (e)) \
      n_errors++; \
  end

module poe_decode_tb
  import poe_pkg::*;
;
  logic        mclk;
  logic        arst_n;
  logic        wb_cyc_i;
  logic        wb_stb_i;
  logic        wb_we_i;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  poe_word_t   wb_dat_i;
  poe_word_t   wb_dat_o;
  logic        wb_ack_o;
  wire  [23:0] oe_vec;
  wire  [23:0] pad_pin;
  poe_word_t   sh [0:9];
  poe_word_t   mk [0:9];
  poe_word_t   can_mb [0:4];
  int          n_errors;
  int          checks_done;

  poe_decode poe_decode_inst (
    .mclk(mclk), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .timer0_pin_a_oe(oe_vec[0]), .timer6_pin_a_oe(oe_vec[1]),
    .timer6_pin_b_oe(oe_vec[2]), .timer6_pin_c_oe(oe_vec[3]), .timer6_pin_d_oe(oe_vec[4]),
    .timer7_pin_a_oe(oe_vec[5]), .timer7_pin_b_oe(oe_vec[6]), .timer8_pin_a_oe(oe_vec[7]),
    .timer8_pin_b_oe(oe_vec[8]), .can_transmit_pin_oe(oe_vec[9]),
    .serial4_clock_pin_oe(oe_vec[10]), .clock_out_oe(oe_vec[11]),
    .sync_serial_data_out_oe(oe_vec[14:12]), .sync_serial_data_in_oe(oe_vec[17:15]),
    .sync_serial_clock_pin_oe(oe_vec[20:18]), .sync_serial_chip_select_oe(oe_vec[23:21]));

  poe_pad_model poe_pad_model_inst (
    .oe(oe_vec), .periph_dat(24'h5A_C3F0), .port_dir(24'hFF_FFFF), .port_dat(24'h0F_0F0F),
    .pin(pad_pin));

  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ==========================================================
  // Bus access
  task automatic wb_cycle(input logic [7:0] a, input logic w, input logic [3:0] s,
                          input poe_word_t d, output poe_word_t q);
    int n;
    n = 0;
    @(posedge mclk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_sel_i <= s;
    wb_dat_i <= d;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 20);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (wb_ack_o !== 1'b1)
    begin
      n_errors++;
      end_of_test();
    end
  endtask

  task automatic wr(input logic [7:0] a, input poe_word_t d, input logic [3:0] s = 4'hF);
    poe_word_t q;
    poe_word_t bm;
    wb_cycle(a, 1'b1, s, d, q);
    // Unmapped, misaligned and status writes leave the model untouched
    if (a[1:0] == 2'b00 && a < `POE_OFS_STATUS)
    begin
      bm = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}} & mk[a[5:2]];
      sh[a[5:2]] = (sh[a[5:2]] & ~bm) | (d & bm);
    end
  endtask

  task automatic rd(input logic [7:0] a, input poe_word_t e);
    poe_word_t q;
    wb_cycle(a, 1'b0, 4'hF, 32'h0000_0000, q);
    `CHK(q, e)
  endtask

  // ==========================================================
  // Expected enables
  function automatic logic tio(input logic [3:0] f);
    return !f[3] && f[1:0] != 2'b00;
  endfunction

  function automatic poe_word_t exp_st();
    poe_word_t s;
    logic [7:0] u;
    logic [6:0] x;
    s = 32'h0000_0000;
    x = sh[5][6:0];
    s[0] = tio(sh[0][3:0]);
    s[1] = tio(sh[1][3:0]);
    s[2] = tio(sh[1][7:4]);
    s[3] = !sh[1][16] && tio(sh[1][11:8]);
    s[4] = !sh[1][17] && tio(sh[1][15:12]);
    for (int k = 0; k < 4; k++)
      s[5 + k] = tio(sh[2][4 * k +: 4]);
    s[9] = sh[4][0] && !sh[4][1] && (|(~sh[3][15:1] & sh[3][31:17]));
    s[10] = (x[5] || x[6]) && (x[0] ? (x[1] || x[4:3] == 2'b01)
                                    : (x[2] ? !x[4] : x[4:3] == 2'b01));
    s[11] = sh[6][0] && !sh[6][1] && !sh[6][2];
    for (int g = 0; g < 3; g++)
    begin
      u = sh[7 + g][7:0];
      s[12 + g] = u[0] ? u[6] : (u[1] ? u[6] && (!u[2] || !u[7]) : u[2] && !u[7] && u[6]);
      s[15 + g] = !u[0] && !u[1] && !u[2] && u[6];
      s[18 + g] = u[1] && u[3];
      s[21 + g] = u[5] && !u[0] && u[1];
    end
    return s;
  endfunction

  task automatic check_all();
    poe_word_t e;
    e = exp_st();
    #1;
    `CHK(oe_vec, e[23:0])
    `CHK(pad_pin, (e[23:0] & 24'h5A_C3F0) | (~e[23:0] & 24'h0F_0F0F))
    rd(`POE_OFS_STATUS, e);
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    n_errors = 0;
    checks_done = 0;
    arst_n = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0000_0000;
    sh = '{default: 32'h0000_0000};
    mk = '{`POE_MASK_TMR0, `POE_MASK_TMR6, `POE_MASK_TMR78, `POE_MASK_CAN_MBOX,
           `POE_MASK_CAN_CTRL, `POE_MASK_SCI4, `POE_MASK_CLKOUT, `POE_MASK_SSU,
           `POE_MASK_SSU, `POE_MASK_SSU};
    // Mailbox 0 alone, receive direction and mailbox 15 probe the mailbox range
    can_mb = '{32'h8000_0000, 32'h0001_0000, 32'h0002_0002, 32'h0004_0000, 32'hFFFE_FFFF};
    repeat (16) @(posedge mclk);
    arst_n <= 1'b1;
    for (int i = 0; i < 11; i++)
      rd(8'(i * 4), `POE_RST_REG);
    check_all();
    for (int i = 0; i < 64; i++)
    begin
      wr(`POE_OFS_TMR0, {28'h0, i[3:0]});
      wr(`POE_OFS_TMR6, {14'h0, i[5:4], i[3:0], ~i[3:0], i[3:0], ~i[3:0]});
      wr(`POE_OFS_TMR78, {16'h0000, i[3:0], ~i[3:0], ~i[3:0], i[3:0]});
      check_all();
    end
    for (int i = 0; i < 20; i++)
    begin
      wr(`POE_OFS_CAN_MBOX, can_mb[i / 4]);
      wr(`POE_OFS_CAN_CTRL, 32'(i % 4));
      check_all();
    end
    for (int i = 0; i < 128; i++)
    begin
      wr(`POE_OFS_SCI4, 32'(i));
      check_all();
    end
    for (int i = 0; i < 8; i++)
    begin
      wr(`POE_OFS_CLKOUT, 32'(i));
      check_all();
    end
    for (int i = 0; i < 256; i++)
    begin
      wr(`POE_OFS_SSU0, 32'(i));
      wr(`POE_OFS_SSU1, {24'h00_0000, ~i[7:0]});
      wr(`POE_OFS_SSU2, {24'h00_0000, i[7:0] ^ 8'h5A});
      check_all();
    end
    // Lane, unmapped, misaligned and read-only writes
    wr(`POE_OFS_TMR6, 32'hFFFF_FFFF, 4'b0100);
    wr(8'h2C, 32'hFFFF_FFFF);
    wr(8'h05, 32'hFFFF_FFFF);
    wr(`POE_OFS_STATUS, 32'hFFFF_FFFF);
    rd(8'h2C, `POE_RD_UNMAPPED);
    rd(8'h05, `POE_RD_UNMAPPED);
    for (int i = 0; i < 10; i++)
      rd(8'(i * 4), sh[i]);
    check_all();
    end_of_test();
  end
endmodule
